// >>> design/slt_loader.sv
// Purpose: Serial bootstrap loader, memory crypto and tamper unlock.
// Assumes: rx bytes come from the on-chip UART on clk_i.
// Notes: Load = partition byte, length hi, length lo, data, checksum.
// Operation
// - Falling loader pin edge starts the loader
// - Pin low at power-up starts loading
// - Loader pin idles high, never requests
// - Tamper high erases keys, vectors, cuts supply
// - Reset input high holds reset state
// - Program bytes arrive over serial port
// - Each loaded byte encrypted before SRAM write
// - Encryption key is 64 bits
// - Keys come from true random source
// - Fresh key generated every load session
// - Loader checks load, then goes transparent
// - Partition set at load, changeable later
// - SRAM accesses go over byte-wide bus
// - Writes into program segment are blocked
// - Extraction attempt destroys secret material
`timescale 1ns/10ps
`default_nettype none
`include "slt_params.svh"
module slt_loader
  import slt_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic loader_entry_pin_i,
  input wire logic tamper_destruct_input_i,
  input wire logic ext_reset_i,
  input wire logic rnd_bit_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  output logic cpu_ack_o,
  output logic cpu_fault_o,
  input wire logic part_we_i,
  input wire logic [7:0] part_i,
  output logic [15:0] sram_addr_o,
  output logic [7:0] sram_wdata_o,
  input wire logic [7:0] sram_rdata_i,
  output logic sram_ce_n_o,
  output logic sram_we_n_o,
  output logic backed_supply_output_o,
  output logic loader_active_o,
  output logic load_ok_o,
  output logic load_err_o
);
  function automatic slt_byte_t slt_ks(input logic [63:0] k, input logic [15:0] a);
    slt_ks = k[{a[2:0], 3'h0} +: 8] ^ a[10:3];
  endfunction : slt_ks

  // Pin synchronisers: 0 loader, 1 tamper, 2 reset, 3 random
  logic [3:0] pin_a;
  logic [3:0] lvl_w;
  assign pin_a = {rnd_bit_i, ext_reset_i, tamper_destruct_input_i, loader_entry_pin_i};
  for (genvar g = 0; g < 4; g++) begin : g_sync
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic lvl_reg;
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        s1_reg <= 1'(`SLT_SYNC_RST >> g);
        s2_reg <= 1'(`SLT_SYNC_RST >> g);
        s3_reg <= 1'(`SLT_SYNC_RST >> g);
        lvl_reg <= 1'(`SLT_SYNC_RST >> g);
      end else begin
        s1_reg <= pin_a[g];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) lvl_reg <= s3_reg;
      end
    end
    assign lvl_w[g] = lvl_reg;
  end

  logic tamp;
  logic rst_lvl;
  logic rnd;
  logic ldr_prev_reg;
  logic ldr_edge;
  assign tamp = lvl_w[1];
  assign rst_lvl = lvl_w[2];
  assign rnd = lvl_w[3];
  // Prev resets high, so a pin held low from power-up also gives an edge
  assign ldr_edge = ldr_prev_reg && !lvl_w[0];

  slt_state_t state_reg, state_next;
  logic [6:0] cnt_reg, cnt_next;
  logic [63:0] key_reg, key_next;
  logic [7:0] part_reg, part_next;
  logic [15:0] len_reg, len_next;
  logic [15:0] waddr_reg, waddr_next;
  logic [1:0] hdr_reg, hdr_next;
  logic [7:0] sum_reg, sum_next;
  logic acc_vec_reg, acc_vec_next;
  logic [7:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic fault_reg, fault_next;
  logic [15:0] saddr_reg, saddr_next;
  logic [7:0] swdata_reg, swdata_next;
  logic ce_n_reg, ce_n_next;
  logic we_n_reg, we_n_next;
  logic ok_reg, ok_next;
  logic err_reg, err_next;
  logic supply_reg, supply_next;

  slt_strm_if #(.W(`SLT_BYTE_W)) rx_s ();
  slt_strm_if #(.W(`SLT_BYTE_W)) fo_s ();
  assign rx_s.valid = rx_valid_i;
  assign rx_s.data = rx_data_i;
  assign rx_ready_o = rx_s.ready;

  slt_fifo #(.W(`SLT_BYTE_W), .DEPTH(`SLT_FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .wr_s(rx_s),
    .rd_s(fo_s)
  );

  logic fo_valid;
  logic [7:0] fo_data;
  logic hdr_hs;
  logic dat_hs;
  logic sum_byte;
  logic sum_hit;
  logic dat_wr;
  logic [7:0] ld_cipher;
  logic quiet;
  logic cpu_go;
  logic is_vec;
  logic prot;
  logic [7:0] rd_plain;
  assign fo_valid = fo_s.valid;
  assign fo_data = fo_s.data;
  assign fo_s.ready = (state_reg == ST_HDR) || (state_reg == ST_DATA);
  assign hdr_hs = (state_reg == ST_HDR) && fo_valid;
  assign dat_hs = (state_reg == ST_DATA) && fo_valid;
  assign sum_byte = dat_hs && (waddr_reg == len_reg);
  assign sum_hit = (fo_data == sum_reg);
  assign dat_wr = dat_hs && !sum_byte;
  assign ld_cipher = fo_data ^ slt_ks(key_reg, waddr_reg);
  assign quiet = !tamp && !rst_lvl && !ldr_edge;
  assign cpu_go = (state_reg == ST_RUN) && cpu_req_i && !rst_lvl;
  assign is_vec = cpu_addr_i < 16'(`SLT_VEC_DEPTH);
  assign prot = cpu_we_i && (cpu_addr_i[15:8] < part_reg);
  assign rd_plain = sram_rdata_i ^ slt_ks(key_reg, saddr_reg);

  logic vram_we;
  logic [4:0] vram_waddr;
  logic [7:0] vram_wdata;
  logic [7:0] vram_rdata;
  logic unl;
  assign unl = (state_reg == ST_UNLOCK);
  assign vram_we = unl || (dat_wr && waddr_reg < 16'(`SLT_VEC_DEPTH))
    || (cpu_go && cpu_we_i && is_vec && !prot);
  assign vram_waddr = unl ? cnt_reg[4:0] : (dat_hs ? waddr_reg[4:0] : cpu_addr_i[4:0]);
  assign vram_wdata = unl ? 8'h00 : (dat_hs ? fo_data : cpu_wdata_i);

  slt_vram #(.W(`SLT_BYTE_W), .DEPTH(`SLT_VEC_DEPTH)) u_vram (
    .clk_i(clk_i),
    .we_i(vram_we),
    .waddr_i(vram_waddr),
    .wdata_i(vram_wdata),
    .raddr_i(cpu_addr_i[4:0]),
    .rdata_o(vram_rdata)
  );

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    key_next = key_reg;
    part_next = part_reg;
    len_next = len_reg;
    waddr_next = waddr_reg;
    hdr_next = hdr_reg;
    sum_next = sum_reg;
    acc_vec_next = acc_vec_reg;
    rdata_next = rdata_reg;
    ack_next = 1'h0;
    fault_next = 1'h0;
    saddr_next = saddr_reg;
    swdata_next = swdata_reg;
    ce_n_next = 1'h1;
    we_n_next = 1'h1;
    ok_next = ok_reg;
    err_next = err_reg;
    supply_next = !(unl && cnt_reg < 7'(`SLT_SUPPLY_OFF_CYC));
    case (state_reg)
      ST_RUN: begin
        if (part_we_i) part_next = part_i;
        if (cpu_go) begin
          state_next = ST_ACCESS;
          acc_vec_next = is_vec;
          fault_next = prot;
          if (!is_vec) begin
            saddr_next = cpu_addr_i;
            swdata_next = cpu_wdata_i ^ slt_ks(key_reg, cpu_addr_i);
            ce_n_next = 1'h0;
            we_n_next = !(cpu_we_i && !prot);
          end
        end
      end
      ST_ACCESS: begin
        ack_next = 1'h1;
        rdata_next = acc_vec_reg ? vram_rdata : rd_plain;
        state_next = ST_RUN;
      end
      ST_KEYGEN: begin
        key_next = {key_reg[62:0], rnd};
        cnt_next = cnt_reg + 7'h01;
        if (cnt_reg == `SLT_KEYGEN_LAST) begin
          state_next = ST_HDR;
          hdr_next = 2'h0;
          sum_next = 8'h00;
        end
      end
      ST_HDR: begin
        if (fo_valid) begin
          hdr_next = hdr_reg + 2'h1;
          waddr_next = 16'h0000;
          if (hdr_reg == 2'h0) part_next = fo_data;
          if (hdr_reg == 2'h1) len_next = {fo_data, len_reg[7:0]};
          if (hdr_reg == `SLT_HDR_LAST) begin
            len_next = {len_reg[15:8], fo_data};
            state_next = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (sum_byte) begin
          ok_next = sum_hit;
          err_next = !sum_hit;
          state_next = ST_RUN;
        end else if (dat_wr) begin
          saddr_next = waddr_reg;
          swdata_next = ld_cipher;
          ce_n_next = 1'h0;
          we_n_next = 1'h0;
          sum_next = sum_reg + fo_data;
          waddr_next = waddr_reg + 16'h0001;
        end
      end
      ST_UNLOCK: begin
        key_next = '0;
        cnt_next = cnt_reg + 7'h01;
        if (cnt_reg == `SLT_UNLOCK_LAST) state_next = ST_RUN;
      end
      default: state_next = ST_RUN;
    endcase
    if (ldr_edge && !unl) begin
      state_next = ST_KEYGEN;
      cnt_next = 7'h00;
      ok_next = sum_byte && ok_next; // Checksum result wins over the clear
      err_next = sum_byte && err_next;
    end
    if (rst_lvl && !unl) begin
      state_next = ST_RUN;
      ce_n_next = 1'h1;
      we_n_next = 1'h1;
      ack_next = 1'h0;
      fault_next = 1'h0;
    end
    if (tamp && !unl) begin
      state_next = ST_UNLOCK;
      cnt_next = 7'h00;
      key_next = '0;
      ok_next = 1'h0;
      err_next = 1'h0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_RUN;
      cnt_reg <= 7'h00;
      key_reg <= '0;
      part_reg <= `SLT_PART_RST;
      len_reg <= 16'h0000;
      waddr_reg <= 16'h0000;
      hdr_reg <= 2'h0;
      sum_reg <= 8'h00;
      acc_vec_reg <= 1'h0;
      rdata_reg <= 8'h00;
      ack_reg <= 1'h0;
      fault_reg <= 1'h0;
      saddr_reg <= 16'h0000;
      swdata_reg <= 8'h00;
      ce_n_reg <= 1'h1;
      we_n_reg <= 1'h1;
      ok_reg <= 1'h0;
      err_reg <= 1'h0;
      supply_reg <= 1'h1;
      ldr_prev_reg <= 1'h1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      key_reg <= key_next;
      part_reg <= part_next;
      len_reg <= len_next;
      waddr_reg <= waddr_next;
      hdr_reg <= hdr_next;
      sum_reg <= sum_next;
      acc_vec_reg <= acc_vec_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      fault_reg <= fault_next;
      saddr_reg <= saddr_next;
      swdata_reg <= swdata_next;
      ce_n_reg <= ce_n_next;
      we_n_reg <= we_n_next;
      ok_reg <= ok_next;
      err_reg <= err_next;
      supply_reg <= supply_next;
      ldr_prev_reg <= lvl_w[0];
    end
  end

  assign cpu_rdata_o = rdata_reg;
  assign cpu_ack_o = ack_reg;
  assign cpu_fault_o = fault_reg;
  assign sram_addr_o = saddr_reg;
  assign sram_wdata_o = swdata_reg;
  assign sram_ce_n_o = ce_n_reg;
  assign sram_we_n_o = we_n_reg;
  assign backed_supply_output_o = supply_reg;
  assign loader_active_o = (state_reg == ST_KEYGEN) || (state_reg == ST_HDR)
    || (state_reg == ST_DATA);
  assign load_ok_o = ok_reg;
  assign load_err_o = err_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  chk_edge_to_keygen: assert property (
    ldr_edge && !tamp && !rst_lvl && !unl |=> state_reg == ST_KEYGEN)
    else $error("loader edge did not start key generation");
  chk_tamper_erase: assert property (
    tamp && !unl |=> state_reg == ST_UNLOCK && key_reg == '0)
    else $error("tamper did not erase key");
  chk_supply_cut: assert property (
    $rose(unl) |=> !backed_supply_output_o [*8])
    else $error("backed supply not cut during unlock");
  chk_reset_idle: assert property (
    rst_lvl && !tamp && !unl |=> state_reg == ST_RUN && sram_ce_n_o)
    else $error("reset level did not hold idle state");
  chk_load_cipher: assert property (
    dat_wr && quiet |=> !sram_we_n_o && sram_wdata_o == $past(ld_cipher))
    else $error("loaded byte not written encrypted");
  chk_key_length: assert property (
    state_reg == ST_KEYGEN && cnt_reg == 7'h3F && quiet
    |=> state_reg == ST_HDR && key_reg[0] == $past(rnd))
    else $error("key generation length wrong");
  chk_checksum_done: assert property (
    sum_byte && quiet |=> load_ok_o == $past(sum_hit) && state_reg == ST_RUN)
    else $error("load validation result wrong");
  chk_partition_load: assert property (
    hdr_hs && hdr_reg == 2'h0 && quiet |=> part_reg == $past(fo_data))
    else $error("partition not taken from header");
  chk_vec_decode: assert property (
    cpu_go && quiet |=> sram_ce_n_o == $past(is_vec))
    else $error("sram decode wrong");
  chk_write_block: assert property (
    cpu_go && prot && quiet |=> sram_we_n_o && cpu_fault_o)
    else $error("program segment write not blocked");
  chk_read_decrypt: assert property (
    state_reg == ST_ACCESS && !acc_vec_reg && quiet
    |=> cpu_ack_o && cpu_rdata_o == $past(rd_plain))
    else $error("read data not decrypted");
endmodule : slt_loader
`default_nettype wire

// >>> inc/slt_params.svh
// Purpose: Constants for the secure loader and tamper control block.
// Assumes: 25 MHz core clock.
// Notes: Times are in ns; the supply-off cycle count derives from them.
`ifndef SLT_PARAMS_SVH
`define SLT_PARAMS_SVH
`define SLT_CLK_NS 40
`define SLT_KEY_W 64
`define SLT_KEYGEN_LAST 7'h3F
`define SLT_VEC_DEPTH 32
`define SLT_VEC_AW 5
`define SLT_FIFO_DEPTH 8
`define SLT_BYTE_W 8
`define SLT_UNLOCK_LAST 7'h1F
`define SLT_SUPPLY_OFF_NS 1000
`define SLT_SUPPLY_OFF_CYC ((`SLT_SUPPLY_OFF_NS + `SLT_CLK_NS - 1) / `SLT_CLK_NS)
`define SLT_PART_RST 8'h80
`define SLT_HDR_LAST 2'h2
`define SLT_SYNC_RST 4'h1
`endif

// >>> inc/slt_pkg.sv
// Purpose: Types shared by the secure loader modules.
// Assumes: Nothing beyond the params header.
// Notes: State codes are fixed binary.
`default_nettype none
package slt_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_KEYGEN = 3'h1,
    ST_HDR = 3'h2,
    ST_DATA = 3'h3,
    ST_ACCESS = 3'h4,
    ST_UNLOCK = 3'h5
  } slt_state_t;
  typedef logic [7:0] slt_byte_t;
endpackage : slt_pkg
`default_nettype wire

// >>> inc/slt_strm_if.sv
// Purpose: Valid/ready byte stream between loader parts.
// Assumes: Single clock domain.
// Notes: Transfer when valid and ready are both high.
`timescale 1ns/10ps
`default_nettype none
interface slt_strm_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : slt_strm_if
`default_nettype wire

// >>> design/slt_fifo.sv
// Purpose: Receive byte FIFO in front of the loader.
// Assumes: DEPTH is a power of two.
// Notes: Ready drops when full so the serial source stalls.
`timescale 1ns/10ps
`default_nettype none
module slt_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  slt_strm_if.snk wr_s,
  slt_strm_if.src rd_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;

  assign empty = (wptr_reg == rptr_reg);
  assign full = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign do_wr = wr_s.valid && !full;
  assign do_rd = rd_s.ready && !empty;
  assign wr_s.ready = !full;
  assign rd_s.valid = !empty;
  assign rd_s.data = mem_reg[rptr_reg[AW-1:0]];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (do_wr) wptr_reg <= wptr_reg + (AW+1)'(1);
      if (do_rd) rptr_reg <= rptr_reg + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_wr) mem_reg[wptr_reg[AW-1:0]] <= wr_s.data;
  end
endmodule : slt_fifo
`default_nettype wire

// >>> design/slt_vram.sv
// Purpose: Plaintext vector RAM kept inside the device.
// Assumes: One write and one read port.
// Notes: Read data is registered, one cycle after the address.
`timescale 1ns/10ps
`default_nettype none
module slt_vram #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem_reg [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) mem_reg[waddr_i] <= wdata_i;
    rdata_o <= mem_reg[raddr_i];
  end
endmodule : slt_vram
`default_nettype wire

// >>> dv/slt_host_model.sv
// Purpose: Host that streams load bytes into the loader.
// Assumes: Bench pushes bytes between clock edges.
// Notes: slow_i spaces bytes; idle data is inverted each cycle.
`timescale 1ns/10ps
`default_nettype none
module slt_host_model
  import slt_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic slow_i,
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  slt_byte_t q[$];
  logic [1:0] cnt_reg;
  task automatic push(input slt_byte_t b);
    q.push_back(b);
  endtask : push
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q.delete();
      cnt_reg <= 2'h0;
      rx_valid_o <= 1'b0;
      rx_data_o <= 8'h5A;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      if (rx_valid_o && rx_ready_i) begin
        q.delete(0);
      end
      if (rx_valid_o && !rx_ready_i) begin
        // Byte held until taken
      end else if (q.size() != 0 && (!slow_i || cnt_reg == 2'h0)) begin
        rx_valid_o <= 1'b1;
        rx_data_o <= q[0];
      end else begin
        rx_valid_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
      end
    end
  end
endmodule : slt_host_model
`default_nettype wire

// >>> dv/slt_loader_tb.sv
// Purpose: Self-checking bench for the secure loader.
// Assumes: Key bits follow a constant random-source level.
// Notes: Loads come first; table rows cover CPU accesses; reset, tamper follow.
`timescale 1ns/10ps
`default_nettype none
module slt_loader_tb
  import slt_pkg::*;
;
  typedef struct packed {
    logic we;
    logic [7:0] part;
    logic [15:0] addr;
    logic [7:0] d;
    logic [7:0] vrd;
    logic flt;
  } slt_row_t;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic loader_entry_pin_i = 1'b1;
  logic tamper_destruct_input_i = 1'b0; // Tamper held low until the tamper test
  logic ext_reset_i = 1'b0;
  logic rnd_bit_i = 1'b1;
  logic cpu_req_i = 1'b0;
  logic cpu_we_i = 1'b0;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic [7:0] cpu_wdata_i = 8'h00;
  logic part_we_i = 1'b0;
  logic [7:0] part_i = 8'h00;
  logic [7:0] sram_rdata_i = 8'h00;
  logic slow = 1'b0;
  logic rx_valid, rx_ready_o, cpu_ack_o, cpu_fault_o, sram_ce_n_o, sram_we_n_o;
  logic backed_supply_output_o, loader_active_o, load_ok_o, load_err_o;
  logic [7:0] rx_data, cpu_rdata_o, sram_wdata_o;
  logic [15:0] sram_addr_o;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int nce = 0;
  logic saw_full = 1'b0;
  logic [23:0] wlog[$];
  slt_byte_t kb;
  slt_row_t rows [7] = '{
    '{1'b1, 8'h10, 16'h1008, 8'h3C, 8'h00, 1'b0},
    '{1'b1, 8'h10, 16'h0F00, 8'h55, 8'h00, 1'b1},
    '{1'b0, 8'h10, 16'h1008, 8'h3D, 8'h00, 1'b0},
    '{1'b0, 8'h10, 16'h0005, 8'h00, 8'h25, 1'b0},
    '{1'b1, 8'h00, 16'h0F00, 8'h55, 8'h00, 1'b0},
    '{1'b1, 8'hFF, 16'hFE10, 8'h11, 8'h00, 1'b1},
    '{1'b0, 8'hFF, 16'h8123, 8'h00, 8'h00, 1'b0}
  };

  slt_loader i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .loader_entry_pin_i(loader_entry_pin_i), .tamper_destruct_input_i(tamper_destruct_input_i),
    .ext_reset_i(ext_reset_i), .rnd_bit_i(rnd_bit_i), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .rx_ready_o(rx_ready_o), .cpu_req_i(cpu_req_i),
    .cpu_we_i(cpu_we_i), .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i),
    .cpu_rdata_o(cpu_rdata_o), .cpu_ack_o(cpu_ack_o), .cpu_fault_o(cpu_fault_o),
    .part_we_i(part_we_i), .part_i(part_i), .sram_addr_o(sram_addr_o),
    .sram_wdata_o(sram_wdata_o), .sram_rdata_i(sram_rdata_i), .sram_ce_n_o(sram_ce_n_o),
    .sram_we_n_o(sram_we_n_o), .backed_supply_output_o(backed_supply_output_o),
    .loader_active_o(loader_active_o), .load_ok_o(load_ok_o), .load_err_o(load_err_o));
  slt_host_model i_host (.clk_i(clk_i), .resetn_i(resetn_i), .slow_i(slow),
    .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid), .rx_data_o(rx_data));

  always #20 clk_i = ~clk_i;

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (sram_ce_n_o === 1'b0) nce <= nce + 1;
    if (sram_ce_n_o === 1'b0 && sram_we_n_o === 1'b0) wlog.push_back({sram_addr_o, sram_wdata_o});
    if (rx_valid === 1'b1 && rx_ready_o === 1'b0) saw_full <= 1'b1;
    if (cyc == 30000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit
  task automatic chk_val(input string name, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val
  function automatic slt_byte_t enc(input logic [15:0] a, input slt_byte_t d);
    return d ^ kb ^ a[10:3];
  endfunction : enc
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic wait_for(input int sel, input int n, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(posedge clk_i);
      #1;
      case (sel)
        0: seen = (loader_active_o === 1'b1);
        1: seen = (loader_active_o === 1'b0);
        default: seen = (backed_supply_output_o === 1'b0);
      endcase
    end
  endtask : wait_for
  task automatic cpu(input logic we, input logic [15:0] a, input slt_byte_t d,
                     output logic ack, output logic flt, output slt_byte_t rd);
    @(posedge clk_i);
    cpu_req_i <= 1'b1;
    cpu_we_i <= we;
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    @(posedge clk_i);
    cpu_req_i <= 1'b0;
    ack = 1'b0;
    flt = 1'b0;
    rd = 8'h00;
    repeat (4) begin
      #1;
      if (cpu_fault_o === 1'b1) flt = 1'b1;
      if (cpu_ack_o === 1'b1 && !ack) begin
        ack = 1'b1;
        rd = cpu_rdata_o;
      end
      @(posedge clk_i);
    end
  endtask : cpu
  task automatic load(input slt_byte_t part, input int n, input slt_byte_t base, input logic bad);
    slt_byte_t sum;
    logic seen;
    int w0;
    sum = 8'h00;
    w0 = wlog.size();
    @(posedge clk_i);
    loader_entry_pin_i <= 1'b0;
    wait_for(0, 12, seen);
    chk_bit("loader entered", 1'b1, seen);
    @(posedge clk_i);
    loader_entry_pin_i <= 1'b1; // One clean edge per request
    @(negedge clk_i);
    i_host.push(part);
    i_host.push(8'h00);
    i_host.push(8'(n));
    for (int i = 0; i < n; i++) begin
      i_host.push(base + 8'(i));
      sum += base + 8'(i);
    end
    i_host.push(sum + 8'(bad));
    wait_for(1, 800, seen);
    chk_bit("loader done", 1'b1, seen);
    tick(2);
    #1;
    chk_bit("load ok", ~bad, load_ok_o);
    chk_bit("load err", bad, load_err_o);
    chk_val("write count", 24'(n), 24'(wlog.size() - w0));
    for (int i = 0; i < n; i++) begin
      chk_val("sram write", {16'(i), enc(16'(i), base + 8'(i))}, wlog[w0 + i]);
    end
  endtask : load

  initial begin
    logic seen, ack, flt, sram;
    logic [23:0] wexp;
    slt_byte_t rd;
    int n0, w0, lo;
    tick(16);
    resetn_i <= 1'b1;
    tick(20);
    #1;
    chk_bit("idle loader", 1'b0, loader_active_o);
    chk_bit("supply on", 1'b1, backed_supply_output_o);
    chk_bit("chip enable", 1'b1, sram_ce_n_o);
    kb = 8'hFF;
    load(8'h40, 10, 8'h20, 1'b0);
    chk_bit("fifo stalled", 1'b1, saw_full);
    @(posedge clk_i);
    rnd_bit_i <= 1'b0;
    slow <= 1'b1;
    tick(4);
    kb = 8'h00;
    load(8'h10, 2, 8'h70, 1'b1);
    foreach (rows[r]) begin
      @(posedge clk_i);
      part_we_i <= 1'b1;
      part_i <= rows[r].part;
      @(posedge clk_i);
      part_we_i <= 1'b0;
      sram_rdata_i <= rows[r].d;
      n0 = nce;
      w0 = wlog.size();
      cpu(rows[r].we, rows[r].addr, rows[r].d, ack, flt, rd);
      #1;
      sram = rows[r].addr >= 16'h0020;
      wexp = {rows[r].addr, enc(rows[r].addr, rows[r].d)};
      chk_bit("fault", rows[r].flt, flt);
      chk_bit("ack", 1'b1, ack);
      chk_val("sram cycles", 24'(sram), 24'(nce - n0));
      chk_val("writes", 24'(rows[r].we && sram && !rows[r].flt), 24'(wlog.size() - w0));
      if (rows[r].we && sram && !rows[r].flt) chk_val("sram write", wexp, wlog[w0]);
      if (!rows[r].we) chk_val("read data", 24'(sram ? wexp[7:0] : rows[r].vrd), 24'(rd));
    end
    @(posedge clk_i);
    ext_reset_i <= 1'b1;
    tick(6);
    n0 = nce;
    cpu(1'b0, 16'h8123, 8'h00, ack, flt, rd);
    chk_bit("ack in reset", 1'b0, ack);
    chk_val("sram in reset", 24'h0, 24'(nce - n0));
    ext_reset_i <= 1'b0;
    tick(6);
    tamper_destruct_input_i <= 1'b1;
    wait_for(2, 10, seen);
    chk_bit("supply cut", 1'b1, seen);
    tamper_destruct_input_i <= 1'b0;
    lo = 0;
    do begin
      lo++;
      @(posedge clk_i);
      #1;
    end while (backed_supply_output_o === 1'b0 && lo < 60);
    chk_val("supply off cycles", 24'h19, 24'(lo));
    tick(20);
    cpu(1'b0, 16'h0005, 8'h00, ack, flt, rd);
    chk_val("vector erased", 24'h0, 24'(rd));
    chk_bit("load err cleared", 1'b0, load_err_o);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    loader_entry_pin_i <= 1'b0;
    tick(4);
    resetn_i <= 1'b1;
    wait_for(0, 12, seen);
    chk_bit("power-up load", 1'b1, seen);
    end_sim();
  end
endmodule : slt_loader_tb
`default_nettype wire
